// ==== hdl/metering_chipset_reset_sequencer.sv ====
`timescale 1ns/100ps
`include "sequencer_regs.svh"

// Behaviour
// RULE_01 - on I2C, writing one to bit zero of port lock register locks I2C
// RULE_02 - on SPI, any write to port lock register locks SPI
// RULE_03 - once locked, protocol change refused until hardware reset
// RULE_04 - processor runs only after run-control register is written with one
// RULE_05 - host initialises RAM registers, writing the last one three times
// RULE_06 - key 0xAD then 0x80 enables processor RAM write protection
// RULE_07 - reading an energy register clears it to zero
// RULE_08 - three disable bits each suppress one pulse output
// RULE_09 - reset pin low stops clock high; frame, reset-enable, selects held high
// RULE_10 - after long reset pin low, reset-enable low and selects pulse eight times
// RULE_11 - after reset-enable rises, quarter-rate remote clock runs continuously
// RULE_12 - reset-complete flag zero during reset, set and interrupt low at end
// RULE_13 - host writes one to clear the flag; interrupt line returns high
// RULE_14 - hardware reset makes I2C the default host port
// RULE_15 - hardware reset restores register defaults and idles the processor
// RULE_16 - chipset soft reset restores defaults but keeps a locked port choice
// RULE_17 - soft reset bit clears at completion; processor left idle
// RULE_18 - chipset soft reset keeps clock, pulses selects, then raises lines
// RULE_19 - remote-only reset bit runs remote sequence and self-clears
// RULE_20 - clock disable plus remote reset stops clock and holds remotes in reset
// RULE_21 - low power keeps all configuration registers intact
// RULE_22 - select high picks temperature sensor, low picks second voltage input
// RULE_23 - reset-complete interrupt is unmaskable, line low until flag cleared
// RULE_24 - reset pin low abandons any running sequence for hardware reset
module metering_chipset_reset_sequencer
  import sequencer_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_n_in,
  input wire logic spi_select_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic energy_pulse_in,
  input wire logic [3:0] temp_select_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  output logic remote_clock_out,
  output logic frame_clock_out,
  output logic reset_enable_out,
  output logic phase_a_select_line_out,
  output logic phase_b_select_line_out,
  output logic phase_c_select_line_out,
  output logic neutral_select_line_out,
  output logic interrupt_line_one_n_out,
  output logic dsp_running_out,
  output logic ram_protect_out,
  output logic spi_active_out,
  output logic port_locked_out,
  output logic pulse_out_one_enable_out,
  output logic pulse_out_two_enable_out,
  output logic pulse_out_three_enable_out
);

  state_t s_reg;
  state_t s_next;

  // ==========================================================
  // default register contents
  function automatic state_t reg_defaults(input state_t cur);
    state_t d;
    d = cur;
    d.gain = {4{`RST_GAIN}};
    d.run = `RST_RUN;
    d.rst_done = 1'b0;
    d.pulse_mode = `RST_PULSE_MODE;
    d.main_setup = `RST_MAIN_SETUP;
    d.remote_ctrl = `RST_REMOTE_CTRL;
    d.key_one = `RST_KEY;
    d.key_two = `RST_KEY;
    d.key_armed = 1'b0;
    d.ram_protect = 1'b0;
    d.energy = 32'h0000_0000;
    return d;
  endfunction : reg_defaults

  // ==========================================================
  // gain register decode
  function automatic logic [2:0] gain_decode(input logic [15:0] addr);
    case (addr)
      `OFS_GAIN_A: gain_decode = 3'h4;
      `OFS_GAIN_B: gain_decode = 3'h5;
      `OFS_GAIN_C: gain_decode = 3'h6;
      `OFS_GAIN_N: gain_decode = 3'h7;
      default: gain_decode = 3'h0;
    endcase
  endfunction : gain_decode

  // ==========================================================
  // read mux
  function automatic logic [31:0] read_mux(input state_t cur, input logic [15:0] addr);
    logic [2:0] g;
    g = gain_decode(addr);
    read_mux = 32'h0000_0000;
    if (g[2]) begin
      read_mux = cur.gain[g[1:0]];
    end else begin
      case (addr)
        `OFS_RUN: read_mux = {16'h0000, cur.run};
        `OFS_ACTIVE_ENERGY: read_mux = cur.energy;
        `OFS_STATUS_ONE: read_mux = {16'h0000, cur.rst_done, 15'h0000};
        `OFS_PULSE_MODE: read_mux = {16'h0000, cur.pulse_mode};
        `OFS_MAIN_SETUP: read_mux = {16'h0000, cur.main_setup};
        `OFS_REMOTE_CTRL: read_mux = {24'h000000, cur.remote_ctrl};
        `OFS_KEY_TWO: read_mux = {24'h000000, cur.key_two};
        `OFS_KEY_ONE: read_mux = {24'h000000, cur.key_one};
        `OFS_PORT_LOCK: read_mux = {31'h0000_0000, cur.port_locked};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction : read_mux

  // ==========================================================
  // next state
  always_comb begin
    logic half_tick;
    logic seq_end;
    logic [2:0] g;
    logic wr;
    logic rd;
    half_tick = 1'b0;
    seq_end = 1'b0;
    g = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    s_next = s_reg;
    s_next.pin_meta = reset_pin_n_in;
    s_next.pin_sync = s_reg.pin_meta;
    s_next.div = s_reg.div + 2'd1;
    half_tick = s_reg.div[0];
    s_next.rvalid = 1'b0;

    case (s_reg.state)
      ST_RUN: begin
        s_next.reset_en = 1'b1;
        s_next.sel = temp_select_in; // [RULE_22]
        s_next.frame_clk = 1'b0;
        if (s_reg.main_setup[`BIT_SOFT_RST]) begin
          s_next = reg_defaults(s_next); // [RULE_16]
          s_next.main_setup[`BIT_SOFT_RST] = 1'b1;
          s_next.kind = KIND_CHIP;
          s_next.half_cnt = 4'h0;
          s_next.state = ST_SEQ;
        end else if (s_reg.remote_ctrl[`BIT_REMOTE_RST] && s_reg.remote_ctrl[`BIT_CLK_DIS]) begin
          s_next.state = ST_LOW_POWER; // [RULE_20]
        end else if (s_reg.remote_ctrl[`BIT_REMOTE_RST]) begin
          s_next.kind = KIND_REMOTE; // [RULE_19]
          s_next.half_cnt = 4'h0;
          s_next.state = ST_SEQ;
        end
      end
      ST_PIN_LOW: begin
        s_next.div = 2'd0;
        if (s_reg.low_cnt != 12'(`RST_LOW_MIN_CYC)) begin
          s_next.low_cnt = s_reg.low_cnt + 12'd1;
        end
        if (s_reg.pin_sync) begin
          if (s_reg.low_cnt == 12'(`RST_LOW_MIN_CYC)) begin
            s_next = reg_defaults(s_next); // [RULE_15]
            s_next.port_spi = 1'b0; // [RULE_14]
            s_next.port_locked = 1'b0;
            s_next.kind = KIND_HW;
            s_next.half_cnt = 4'h0;
            s_next.state = ST_SEQ; // [RULE_10]
          end else begin
            s_next.state = ST_RUN;
          end
        end
      end
      ST_SEQ: begin
        s_next.reset_en = 1'b0; // [RULE_10] [RULE_18]
        s_next.frame_clk = 1'b0;
        s_next.sel = {4{~s_reg.half_cnt[0]}};
        if (half_tick) begin
          s_next.half_cnt = s_reg.half_cnt + 4'd1;
          seq_end = (s_reg.half_cnt == 4'(`SEL_HALVES - 1));
        end
        if (seq_end) begin
          s_next.reset_en = 1'b1; // [RULE_18]
          s_next.sel = temp_select_in;
          s_next.state = ST_RUN;
          if (s_reg.kind == KIND_REMOTE) begin
            s_next.remote_ctrl[`BIT_REMOTE_RST] = 1'b0; // [RULE_19]
          end else begin
            s_next.rst_done = 1'b1; // [RULE_12]
            s_next.main_setup[`BIT_SOFT_RST] = 1'b0; // [RULE_17]
          end
        end
      end
      ST_LOW_POWER: begin
        s_next.reset_en = 1'b0; // [RULE_20]
        s_next.sel = 4'hF;
        if (!s_reg.remote_ctrl[`BIT_REMOTE_RST]) begin
          s_next.reset_en = 1'b1;
          s_next.state = ST_RUN; // [RULE_21]
        end else if (!s_reg.remote_ctrl[`BIT_CLK_DIS]) begin
          s_next.kind = KIND_REMOTE;
          s_next.half_cnt = 4'h0;
          s_next.state = ST_SEQ;
        end
      end
      default: begin
        s_next.state = ST_RUN;
      end
    endcase

    // ==========================================================
    // host accesses
    wr = reg_wr_in && (s_reg.state != ST_PIN_LOW);
    rd = reg_rd_in && (s_reg.state != ST_PIN_LOW);
    g = gain_decode(reg_addr_in);
    if (rd) begin
      s_next.rdata = read_mux(s_reg, reg_addr_in);
      s_next.rvalid = 1'b1;
      if (reg_addr_in == `OFS_ACTIVE_ENERGY) begin
        s_next.energy = 32'h0000_0000; // [RULE_07]
      end
    end
    if (energy_pulse_in) begin
      s_next.energy = s_next.energy + 32'd1;
    end
    if (spi_select_in && !s_reg.port_locked) begin
      s_next.port_spi = 1'b1; // [RULE_03]
    end
    if (wr) begin
      if (g[2] && !s_reg.ram_protect) begin
        s_next.gain[g[1:0]] = reg_wdata_in; // [RULE_06]
      end
      case (reg_addr_in)
        `OFS_RUN: s_next.run = reg_wdata_in[15:0]; // [RULE_04]
        `OFS_STATUS_ONE: begin
          if (reg_wdata_in[`BIT_RST_DONE] && !seq_end) begin
            s_next.rst_done = 1'b0; // [RULE_13]
          end
        end
        `OFS_PULSE_MODE: s_next.pulse_mode = reg_wdata_in[15:0]; // [RULE_08]
        `OFS_MAIN_SETUP: begin
          if (s_reg.state != ST_SEQ || s_reg.kind == KIND_REMOTE) begin
            s_next.main_setup = reg_wdata_in[15:0];
          end
        end
        `OFS_REMOTE_CTRL: begin
          if (!(seq_end && !reg_wdata_in[`BIT_REMOTE_RST])) begin
            s_next.remote_ctrl = reg_wdata_in[7:0];
          end
          if (seq_end && s_reg.kind == KIND_REMOTE) begin
            s_next.remote_ctrl[`BIT_REMOTE_RST] = 1'b0;
          end
        end
        `OFS_KEY_ONE: begin
          s_next.key_one = reg_wdata_in[7:0];
          s_next.key_armed = (reg_wdata_in[7:0] == `KEY_ONE_VAL); // [RULE_06]
        end
        `OFS_KEY_TWO: begin
          s_next.key_two = reg_wdata_in[7:0];
          s_next.key_armed = 1'b0;
          if (s_reg.key_armed && reg_wdata_in[7:0] == `KEY_TWO_VAL) begin
            s_next.ram_protect = 1'b1; // [RULE_06]
          end
        end
        `OFS_PORT_LOCK: begin
          if (s_reg.port_spi || reg_wdata_in[`BIT_I2C_LOCK]) begin
            s_next.port_locked = 1'b1; // [RULE_01] [RULE_02]
          end
        end
        default: begin
          s_next.run = s_next.run;
        end
      endcase
    end

    // ==========================================================
    // reset pin overrides everything
    if (!s_reg.pin_sync && s_reg.state != ST_PIN_LOW) begin
      s_next.state = ST_PIN_LOW; // [RULE_24]
      s_next.low_cnt = 12'd0;
      s_next.rst_done = 1'b0; // [RULE_12]
    end
    if (s_next.state == ST_PIN_LOW) begin
      s_next.reset_en = 1'b1; // [RULE_09]
      s_next.frame_clk = 1'b1;
      s_next.sel = 4'hF;
      s_next.rvalid = 1'b0;
    end

    // remote clock: held high in hardware reset, stopped when disabled
    if (s_next.state == ST_PIN_LOW || (s_next.state == ST_SEQ && s_next.kind == KIND_HW)
        || s_next.remote_ctrl[`BIT_CLK_DIS]) begin
      s_next.remote_clk = 1'b1; // [RULE_09] [RULE_20]
    end else begin
      s_next.remote_clk = ~s_next.div[1]; // [RULE_11] [RULE_18]
    end
    s_next.irq_n = ~s_next.rst_done; // [RULE_23]
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      s_reg.pin_meta <= 1'b1;
      s_reg.pin_sync <= 1'b1;
      s_reg.state <= ST_RUN;
      s_reg.kind <= KIND_HW;
      s_reg.remote_clk <= 1'b1;
      s_reg.reset_en <= 1'b1;
      s_reg.sel <= 4'hF;
      s_reg.irq_n <= 1'b1;
      s_reg.pulse_mode <= `RST_PULSE_MODE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_out = s_reg.rdata;
  assign reg_rdata_valid_out = s_reg.rvalid;
  assign remote_clock_out = s_reg.remote_clk;
  assign frame_clock_out = s_reg.frame_clk;
  assign reset_enable_out = s_reg.reset_en;
  assign phase_a_select_line_out = s_reg.sel[0];
  assign phase_b_select_line_out = s_reg.sel[1];
  assign phase_c_select_line_out = s_reg.sel[2];
  assign neutral_select_line_out = s_reg.sel[3];
  assign interrupt_line_one_n_out = s_reg.irq_n;
  assign dsp_running_out = (s_reg.run == `RUN_START); // [RULE_04]
  assign ram_protect_out = s_reg.ram_protect;
  assign spi_active_out = s_reg.port_spi;
  assign port_locked_out = s_reg.port_locked;
  assign pulse_out_one_enable_out = ~s_reg.pulse_mode[`BIT_PULSE_ONE_DIS]; // [RULE_08]
  assign pulse_out_two_enable_out = ~s_reg.pulse_mode[`BIT_PULSE_TWO_DIS];
  assign pulse_out_three_enable_out = ~s_reg.pulse_mode[`BIT_PULSE_THREE_DIS];

endmodule : metering_chipset_reset_sequencer

// ==== hdl/sequencer_regs.svh ====
`ifndef SEQUENCER_REGS_SVH
`define SEQUENCER_REGS_SVH

// ==========================================================
// register offsets
`define OFS_GAIN_A 16'h4380
`define OFS_GAIN_B 16'h4383
`define OFS_GAIN_C 16'h4386
`define OFS_GAIN_N 16'h4389
`define OFS_RAM_LO 16'h4380
`define OFS_RAM_HI 16'h43BF
`define OFS_RUN 16'hE228
`define OFS_ACTIVE_ENERGY 16'hE400
`define OFS_STATUS_ONE 16'hE503
`define OFS_PULSE_MODE 16'hE610
`define OFS_MAIN_SETUP 16'hE618
`define OFS_REMOTE_CTRL 16'hE708
`define OFS_KEY_TWO 16'hE7E3
`define OFS_KEY_ONE 16'hE7FE
`define OFS_PORT_LOCK 16'hEA00

// ==========================================================
// field positions
`define BIT_I2C_LOCK 0
`define BIT_RST_DONE 15
`define BIT_PULSE_ONE_DIS 9
`define BIT_PULSE_TWO_DIS 10
`define BIT_PULSE_THREE_DIS 11
`define BIT_SOFT_RST 7
`define BIT_REMOTE_RST 7
`define BIT_CLK_DIS 6

// ==========================================================
// reset values and keys
`define RST_RUN 16'h0000
`define RUN_START 16'h0001
`define RST_PULSE_MODE 16'h0E00
`define RST_MAIN_SETUP 16'h0000
`define RST_REMOTE_CTRL 8'h00
`define RST_KEY 8'h00
`define RST_GAIN 32'h0000_0000
`define KEY_ONE_VAL 8'hAD
`define KEY_TWO_VAL 8'h80

// ==========================================================
// timing
`define CLK_FREQ_MHZ 250
`define RST_LOW_MIN_US 10
`define RST_LOW_MIN_CYC (`RST_LOW_MIN_US * `CLK_FREQ_MHZ)
`define SEL_PULSES 8
`define SEL_HALVES (2 * `SEL_PULSES)

`endif

// ==== hdl/sequencer_pkg.sv ====
package sequencer_pkg;

  // ==========================================================
  // sequencer states and reset kinds
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_PIN_LOW = 4'b0010,
    ST_SEQ = 4'b0100,
    ST_LOW_POWER = 4'b1000
  } seq_state_t;

  typedef enum logic [2:0] {
    KIND_HW = 3'b001,
    KIND_CHIP = 3'b010,
    KIND_REMOTE = 3'b100
  } seq_kind_t;

  // ==========================================================
  // whole module state
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    seq_state_t state;
    seq_kind_t kind;
    logic [11:0] low_cnt;
    logic [1:0] div;
    logic [3:0] half_cnt;
    logic remote_clk;
    logic frame_clk;
    logic reset_en;
    logic [3:0] sel;
    logic irq_n;
    logic [3:0][31:0] gain;
    logic [15:0] run;
    logic rst_done;
    logic [15:0] pulse_mode;
    logic [15:0] main_setup;
    logic [7:0] remote_ctrl;
    logic [7:0] key_one;
    logic [7:0] key_two;
    logic key_armed;
    logic ram_protect;
    logic port_spi;
    logic port_locked;
    logic [31:0] energy;
    logic [31:0] rdata;
    logic rvalid;
  } state_t;

endpackage : sequencer_pkg

// ==== verification/sequencer_monitor.sv ====
`timescale 1ns/100ps
`include "sequencer_regs.svh"

// ====================
// port checker
module sequencer_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic remote_clock_out,
  input wire logic frame_clock_out,
  input wire logic reset_enable_out,
  input wire logic phase_a_select_line_out,
  input wire logic phase_b_select_line_out,
  input wire logic phase_c_select_line_out,
  input wire logic neutral_select_line_out,
  input wire logic interrupt_line_one_n_out,
  input wire logic dsp_running_out,
  input wire logic spi_active_out,
  input wire logic port_locked_out,
  input wire logic pulse_out_one_enable_out,
  input wire logic pulse_out_two_enable_out,
  input wire logic pulse_out_three_enable_out
);
  logic [3:0] sel;
  logic [2:0] dis;
  logic [4:0] fall_cnt_reg;
  logic sel_prev_reg;

  assign sel = {neutral_select_line_out, phase_c_select_line_out, phase_b_select_line_out,
    phase_a_select_line_out};
  assign dis = reg_wdata_in[11:9];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ====================
  // select falls while remotes are held in reset
  always_ff @(posedge clk_in) begin
    sel_prev_reg <= sel[0];
    if (!rst_n_in || reset_enable_out) begin
      fall_cnt_reg <= 5'h00;
    end else if (sel_prev_reg && !sel[0]) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end

  sequence pin_ok;
    reset_pin_n_in [*5];
  endsequence

  // ====================
  // assertions
  AST_PIN_LOW_LINES: assert property (
    (!reset_pin_n_in) [*6] |-> remote_clock_out && frame_clock_out && reset_enable_out
      && sel == 4'hF && interrupt_line_one_n_out)
    else $error("lines not parked high");
  AST_CLOCK_RUNS: assert property (
    (reset_pin_n_in && reset_enable_out) [*8] |-> remote_clock_out != $past(remote_clock_out, 2))
    else $error("remote clock not at quarter rate");
  AST_SEQ_START: assert property (
    pin_ok ##0 (reg_wr_in && reset_enable_out && reg_wdata_in[7]
      && (reg_addr_in == `OFS_MAIN_SETUP || reg_addr_in == `OFS_REMOTE_CTRL))
      |-> ##[1:3] !reset_enable_out)
    else $error("reset sequence not started");
  AST_SELECTS_TOGETHER: assert property (
    !reset_enable_out |-> sel == 4'h0 || sel == 4'hF)
    else $error("select lines differ in reset");
  AST_EIGHT_PULSES: assert property (
    pin_ok ##0 $rose(reset_enable_out) |-> fall_cnt_reg == 5'h08 || fall_cnt_reg == 5'h00)
    else $error("select pulse count wrong");
  AST_FLAG_STICKY: assert property (
    (reset_pin_n_in && !reg_wr_in) [*3] ##0 !interrupt_line_one_n_out
      |=> !interrupt_line_one_n_out)
    else $error("interrupt released without clear");
  AST_PULSE_ENABLES: assert property (
    pin_ok ##0 (reg_wr_in && reg_addr_in == `OFS_PULSE_MODE) |=> {pulse_out_three_enable_out,
      pulse_out_two_enable_out, pulse_out_one_enable_out} == ~$past(dis))
    else $error("pulse enables wrong");
  AST_LOCK_KEEPS_PORT: assert property (
    port_locked_out ##1 port_locked_out |-> $stable(spi_active_out))
    else $error("port changed while locked");
  AST_RUN_NEEDS_WRITE: assert property (
    $rose(dsp_running_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == `OFS_RUN
      && $past(reg_wdata_in) == 32'h0000_0001)
    else $error("processor started without run write");

  cover property ($fell(reset_enable_out));
  cover property ($fell(interrupt_line_one_n_out));
  cover property ($rose(port_locked_out));
endmodule : sequencer_monitor

bind metering_chipset_reset_sequencer sequencer_monitor monitor_u (.*);

// ==== verification/remote_adc_model.sv ====
`timescale 1ns/100ps

// ====================
// remote converters behind the reset lines
module remote_adc_model (
  input wire logic clk_in,
  input wire logic remote_clock_in,
  input wire logic reset_enable_in,
  input wire logic [3:0] select_lines_in,
  output logic [4:0] pulse_count_out,
  output logic [7:0] clock_edges_out,
  output logic [3:0] temp_sensing_out
);
  logic [3:0] sel_prev;
  logic clk_prev;
  logic en_prev;

  initial begin
    pulse_count_out = 5'h00;
    clock_edges_out = 8'h00;
  end
  always @(posedge clk_in) begin
    sel_prev <= select_lines_in;
    clk_prev <= remote_clock_in;
    en_prev <= reset_enable_in;
    if (en_prev && !reset_enable_in) begin
      pulse_count_out <= 5'h00;
      clock_edges_out <= 8'h00;
    end else if (!reset_enable_in) begin
      if (sel_prev == 4'hF && select_lines_in == 4'h0) begin
        pulse_count_out <= pulse_count_out + 5'h01;
      end
      if (!clk_prev && remote_clock_in) begin
        clock_edges_out <= clock_edges_out + 8'h01;
      end
    end
  end
  // select high picks the temperature sensor once running
  assign temp_sensing_out = reset_enable_in ? select_lines_in : 4'h0;
endmodule : remote_adc_model

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`include "sequencer_regs.svh"

// ====================
// top of the bench
module testbench;
  logic clk_in, rst_n_in, reset_pin_n_in, spi_select_in, reg_wr_in, reg_rd_in, energy_pulse_in;
  logic [15:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, v;
  logic [3:0] temp_select_in, sels, temp_seen;
  logic reg_rdata_valid_out, remote_clock_out, frame_clock_out, reset_enable_out;
  logic phase_a_select_line_out, phase_b_select_line_out, phase_c_select_line_out;
  logic neutral_select_line_out, interrupt_line_one_n_out, dsp_running_out, ram_protect_out;
  logic spi_active_out, port_locked_out, pulse_out_one_enable_out, pulse_out_two_enable_out;
  logic pulse_out_three_enable_out;
  logic [7:0] lines, flags, edges;
  logic [4:0] pulses;
  int miscompares, check_count, n;

  assign sels = {neutral_select_line_out, phase_c_select_line_out, phase_b_select_line_out,
    phase_a_select_line_out};
  assign lines = {remote_clock_out, frame_clock_out, reset_enable_out, sels,
    interrupt_line_one_n_out};
  assign flags = {1'b0, dsp_running_out, ram_protect_out, spi_active_out, port_locked_out,
    pulse_out_three_enable_out, pulse_out_two_enable_out, pulse_out_one_enable_out};

  metering_chipset_reset_sequencer dut_u (.*);
  remote_adc_model remote_u (.clk_in(clk_in), .remote_clock_in(remote_clock_out),
    .reset_enable_in(reset_enable_out), .select_lines_in(sels), .pulse_count_out(pulses),
    .clock_edges_out(edges), .temp_sensing_out(temp_seen));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ====================
  // access and compare tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    d = (reg_rdata_valid_out === 1'b1) ? reg_rdata_out : 32'hFFFF_FFFF;
  endtask : rd

  task automatic rc(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask : rc

  task automatic fc(input string name, input logic [7:0] exp);
    @(negedge clk_in);
    chk(name, {24'h000000, flags}, {24'h000000, exp});
  endtask : fc

  task automatic spi_pulse;
    @(negedge clk_in);
    spi_select_in = 1'b1;
    @(negedge clk_in);
    spi_select_in = 1'b0;
  endtask : spi_pulse

  task automatic wait_seq;
    int k;
    k = 0;
    while (reset_enable_out !== 1'b0 && k < 20) begin
      @(negedge clk_in);
      k++;
    end
    while (reset_enable_out !== 1'b1 && k < 200) begin
      @(negedge clk_in);
      k++;
    end
    repeat (2) @(negedge clk_in);
  endtask : wait_seq

  task automatic pin_reset;
    @(negedge clk_in);
    reset_pin_n_in = 1'b0;
    repeat (`RST_LOW_MIN_CYC + 100) @(negedge clk_in);
    chk("parked", {24'h000000, lines}, 32'h0000_00FF);
    reset_pin_n_in = 1'b1;
    wait_seq;
    chk("hw_pulses", {27'h0, pulses}, 32'h0000_0008);
    chk("hw_edges", {24'h000000, edges}, 32'h0000_0000);
  endtask : pin_reset

  task automatic end_checks;
    chk("end_lines", {25'h0, lines[6:0]}, 32'h0000_0034);
    chk("temp", {28'h0, temp_seen}, 32'h0000_000A);
    rc("done", `OFS_STATUS_ONE, 32'h0000_8000);
    wr(`OFS_STATUS_ONE, 32'h0000_8000);
    rc("cleared", `OFS_STATUS_ONE, 32'h0000_0000);
    chk("irq", {31'h0, interrupt_line_one_n_out}, 32'h0000_0001);
  endtask : end_checks

  task automatic defaults;
    rc("run_d", `OFS_RUN, 32'h0000_0000);
    rc("mode_d", `OFS_PULSE_MODE, {16'h0000, `RST_PULSE_MODE});
    rc("setup_d", `OFS_MAIN_SETUP, 32'h0000_0000);
    rc("gain_d", `OFS_GAIN_A, `RST_GAIN);
  endtask : defaults

  task automatic conclude;
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ====================
  // watchdog, several times the expected run
  initial begin
    #200000;
    miscompares++;
    conclude;
  end

  // ====================
  // scenarios
  initial begin
    rst_n_in = 1'b0;
    reset_pin_n_in = 1'b1;
    spi_select_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    energy_pulse_in = 1'b0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 32'h0000_0000;
    temp_select_in = 4'hA;
    miscompares = 0;
    check_count = 0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    wr(`OFS_PORT_LOCK, 32'h0000_0001);
    spi_pulse;
    fc("i2c_lock", 8'h08);
    pin_reset;
    end_checks;
    fc("hw_port", 8'h00);
    defaults;
    spi_pulse;
    wr(`OFS_PORT_LOCK, 32'h0000_0000);
    fc("spi_lock", 8'h18);
    for (n = 0; n < 4; n++) begin
      wr(`OFS_GAIN_A + 16'(3 * n), 32'h0000_0100 + 32'(n));
    end
    repeat (2) wr(`OFS_GAIN_N, 32'h0000_0103);
    wr(`OFS_KEY_ONE, {24'h000000, `KEY_ONE_VAL});
    wr(`OFS_KEY_TWO, {24'h000000, `KEY_TWO_VAL});
    wr(`OFS_RUN, {16'h0000, `RUN_START});
    fc("prot_run", 8'h78);
    wr(`OFS_GAIN_A, 32'h0000_5A5A);
    rc("gain_prot", `OFS_GAIN_A, 32'h0000_0100);
    repeat (3) begin
      @(negedge clk_in);
      energy_pulse_in = 1'b1;
      @(negedge clk_in);
      energy_pulse_in = 1'b0;
    end
    rc("energy", `OFS_ACTIVE_ENERGY, 32'h0000_0003);
    rc("energy_clr", `OFS_ACTIVE_ENERGY, 32'h0000_0000);
    for (n = 0; n < 3; n++) begin
      wr(`OFS_PULSE_MODE, 32'h0000_0E00 & ~(32'h0000_0200 << n));
      fc("pulse_en", 8'h78 | (8'h01 << n));
    end
    wr(`OFS_PULSE_MODE, 32'h0000_0000);
    wr(`OFS_REMOTE_CTRL, 32'h0000_0080);
    v = 32'h0000_0080;
    for (n = 0; n < 40 && v[7] !== 1'b0; n++) begin
      rd(`OFS_REMOTE_CTRL, v);
    end
    chk("remote_bit", v, 32'h0000_0000);
    chk("remote_pulses", {27'h0, pulses}, 32'h0000_0008);
    fc("remote_keep", 8'h7F);
    wr(`OFS_REMOTE_CTRL, 32'h0000_00C0);
    repeat (20) @(negedge clk_in);
    chk("lp_lines", {24'h000000, lines}, 32'h0000_009F);
    chk("lp_edges", {24'h000000, edges}, 32'h0000_0000);
    rc("lp_gain", `OFS_GAIN_A, 32'h0000_0100);
    wr(`OFS_REMOTE_CTRL, 32'h0000_0000);
    fc("lp_exit", 8'h7F);
    chk("lp_en", {31'h0, reset_enable_out}, 32'h0000_0001);
    wr(`OFS_MAIN_SETUP, 32'h0000_0080);
    wait_seq;
    chk("soft_pulses", {27'h0, pulses}, 32'h0000_0008);
    chk("soft_clock", {31'h0, edges != 8'h00}, 32'h0000_0001);
    end_checks;
    defaults;
    fc("soft_port", 8'h18);
    wr(`OFS_MAIN_SETUP, 32'h0000_0080);
    repeat (8) @(negedge clk_in);
    pin_reset;
    end_checks;
    fc("abort_port", 8'h00);
    conclude;
  end
endmodule : testbench
